// ===== bench/epw_egress_pref_props.sv
// Port checks of the egress preference block.
// Assumes one pclk domain and presetn as its reset.
`timescale 1ns/100ps
`default_nettype none
`include "epw_map.vh"
module epw_egress_pref_props
(
  // Clock, reset and APB.
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [`EPW_ADDR_W-1:0] paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Queues.
  input wire logic                   mc_valid_p2,
  input wire logic                   uc_valid_p2,
  input wire logic                   grant_mc_p2,
  input wire logic                   grant_uc_p2,
  input wire logic                   mc_valid_p3,
  input wire logic                   uc_valid_p3,
  input wire logic                   grant_mc_p3,
  input wire logic                   grant_uc_p3
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && paddr == `EPW_OFS_PRIO2;
  endsequence
  sequence s_done;
    psel && penable && pready && !pslverr;
  endsequence
  property p_reg_ok; s_setup ##1 penable |-> s_done; endproperty
  a_reg_ok: assert property (p_reg_ok) else $error("prio2 access failed");
  property p_one2; !(grant_mc_p2 && grant_uc_p2); endproperty
  a_one2: assert property (p_one2) else $error("two grants g2");
  property p_one3; !(grant_mc_p3 && grant_uc_p3); endproperty
  a_one3: assert property (p_one3) else $error("two grants g3");
  property p_mc2; mc_valid_p2 && !uc_valid_p2 |-> grant_mc_p2; endproperty
  a_mc2: assert property (p_mc2) else $error("lone mc not sent g2");
  property p_uc3; uc_valid_p3 && !mc_valid_p3 |-> grant_uc_p3; endproperty
  a_uc3: assert property (p_uc3) else $error("lone uc not sent g3");
  property p_busy2; mc_valid_p2 && uc_valid_p2 |-> grant_mc_p2 || grant_uc_p2; endproperty
  a_busy2: assert property (p_busy2) else $error("idle with work g2");
  property p_idle3; !mc_valid_p3 |-> !grant_mc_p3; endproperty
  a_idle3: assert property (p_idle3) else $error("mc grant empty g3");
  property p_idle2; !uc_valid_p2 |-> !grant_uc_p2; endproperty
  a_idle2: assert property (p_idle2) else $error("uc grant empty g2");
endmodule
bind epw_egress_pref epw_egress_pref_props u_props
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .mc_valid_p2(mc_valid_p2),
  .uc_valid_p2(uc_valid_p2), .grant_mc_p2(grant_mc_p2), .grant_uc_p2(grant_uc_p2),
  .mc_valid_p3(mc_valid_p3), .uc_valid_p3(uc_valid_p3), .grant_mc_p3(grant_mc_p3),
  .grant_uc_p3(grant_uc_p3)
);
`default_nettype wire

// ===== bench/epw_egress_pref_tb.sv
// Bench of the egress preference block: APB master and two queue models.
// Assumes the zero-wait APB slave and combinational grants of the block.
`timescale 1ns/100ps
`default_nettype none
`include "epw_map.vh"
module epw_egress_pref_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:2]  mc_on = 2'h0;
  logic [3:2]  uc_on = 2'h0;
  logic [3:2]  go = 2'h0;
  logic [3:2]  mv, uv, tk, gm, gu;
  logic [31:0] rd;
  logic        er;
  int          n_errors = 0;
  int          n_tests = 0;
  always #20 pclk = ~pclk;
  epw_egress_pref dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mc_valid_p2(mv[2]), .uc_valid_p2(uv[2]), .take_p2(tk[2]),
    .grant_mc_p2(gm[2]), .grant_uc_p2(gu[2]), .mc_valid_p3(mv[3]), .uc_valid_p3(uv[3]),
    .take_p3(tk[3]), .grant_mc_p3(gm[3]), .grant_uc_p3(gu[3])
  );
  epw_queue_model q2_u (.mc_on(mc_on[2]), .uc_on(uc_on[2]), .go(go[2]), .grant_mc(gm[2]),
    .grant_uc(gu[2]), .mc_valid(mv[2]), .uc_valid(uv[2]), .take(tk[2]));
  epw_queue_model q3_u (.mc_on(mc_on[3]), .uc_on(uc_on[3]), .go(go[3]), .grant_mc(gm[3]),
    .grant_uc(gu[3]), .mc_valid(mv[3]), .uc_valid(uv[3]), .take(tk[3]));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Only the watchdog ends a wait for pready.
  task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bit i of e is the type of the i-th packet sent: 1 unicast, 0 multicast.
  task run(input int g, input int n, input logic [7:0] e);
    @(posedge pclk);
    go[g] <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(negedge pclk);
      chk({gm[g], gu[g]}, {~e[i], e[i]});
    end
    @(posedge pclk);
    go[g] <= 1'b0;
  endtask
  task t_regs;
    apb(0, `EPW_OFS_PRIO2, 0); chk(rd, 32'h00000000);
    apb(1, `EPW_OFS_PRIO2, 32'hFFFFFFFF);
    apb(0, `EPW_OFS_PRIO2, 0); chk(rd, 32'h0300000F);
    pstrb <= 4'h1;
    apb(1, `EPW_OFS_PRIO2, 32'h00000000);
    pstrb <= 4'hF;
    apb(0, `EPW_OFS_PRIO2, 0); chk(rd, 32'h03000000);
    apb(0, `EPW_OFS_PRIO3, 0); chk(rd, 32'h00000000);
    apb(0, 20'h1B020, 0); chk(er, 1'b1);
    $display("t_regs done");
  endtask
  task t_off;
    apb(1, `EPW_OFS_PRIO2, 32'h0100000F);
    mc_on[2] <= 1'b1; uc_on[2] <= 1'b1;
    run(2, 4, 8'h05);
    $display("t_off done");
  endtask
  task t_on;
    apb(1, `EPW_OFS_PRIO2, 32'h03000002);
    run(2, 6, 8'h1B);
    apb(1, `EPW_OFS_PRIO3, 32'h02000003);
    mc_on[3] <= 1'b1; uc_on[3] <= 1'b1;
    run(3, 6, 8'h08);
    apb(0, `EPW_OFS_STATUS, 0); chk(rd, 32'h00000200);
    $display("t_on done");
  endtask
  task t_alone;
    uc_on[2] <= 1'b0;
    mc_on[3] <= 1'b0;
    run(2, 3, 8'h00);
    run(3, 2, 8'h03);
    apb(0, `EPW_OFS_STATUS, 0); chk(rd, 32'h00001000);
    $display("t_alone done");
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_off;
    t_on;
    t_alone;
    end_of_test;
  end
  initial
  begin
    repeat (3000) @(posedge pclk);
    n_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire

// ===== bench/epw_queue_model.sv
// Queue pair of one priority group on the scheduler side.
// Assumes grants come combinationally from the valids.
`timescale 1ns/100ps
`default_nettype none
module epw_queue_model
(
  // Bench control.
  input  wire logic mc_on,
  input  wire logic uc_on,
  input  wire logic go,
  // Block side.
  input  wire logic grant_mc,
  input  wire logic grant_uc,
  output logic      mc_valid,
  output logic      uc_valid,
  output logic      take
);
  assign mc_valid = mc_on;
  assign uc_valid = uc_on;
  // A stalled scheduler leaves the grant standing, unconsumed.
  assign take = go & (grant_mc | grant_uc);
endmodule
`default_nettype wire

// ===== shared/epw_map.vh
// Address map, field layout, reset values and codes of the egress
// multicast/unicast preference block.
// Assumes a 32-bit APB slave with byte addresses on paddr.
//
// Function
// - Every port keeps separate preference settings for priority groups 2 and 3.
// - Weighted preference enable sits at bit 6, read/write, resets to zero.
// - Enable low: no type is favoured; select and weight are ignored.
// - Enable high: the weight applies to the selected preferred type.
// - Preferred-type select is bit 7: 0 multicast, 1 unicast.
// - Weight is bits 28 to 31: preferred packets sent between non-preferred ones.
`ifndef EPW_MAP_VH
`define EPW_MAP_VH

`define EPW_ADDR_W        20
`define EPW_OFS_PRIO2     20'h1B018
`define EPW_OFS_PRIO3     20'h1B01C
`define EPW_OFS_STATUS    20'h1B0F0

// Field bits are counted with bit 0 as the most significant, so
// bit 6 is [25], bit 7 is [24] and bits 28 to 31 are [3:0].
`define EPW_BIT_ENABLE    25
`define EPW_BIT_SELECT    24
`define EPW_WEIGHT_HI     3
`define EPW_WEIGHT_LO     0
`define EPW_WEIGHT_MAX    4'hF

`define EPW_RESET_VALUE   32'h00000000
`define EPW_SEL_MCAST     1'b0
`define EPW_SEL_UCAST     1'b1

// Status register layout.
`define EPW_ST_CNT2_LO    0
`define EPW_ST_LAST2      4
`define EPW_ST_CNT3_LO    8
`define EPW_ST_LAST3      12

`endif

// ===== src/epw_egress_pref.v
// Egress multicast/unicast preference for priority groups 2 and 3 of one
// egress port, with its APB register slave.
// Assumes APB master signals synchronous to pclk and queue flags driven
// by the egress scheduler of the same port.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "epw_map.vh"

module epw_egress_pref
(
  // APB clock and reset.
  input  wire                   pclk,
  input  wire                   presetn,
  // APB slave.
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`EPW_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // Priority group 2 queues.
  input  wire                   mc_valid_p2,
  input  wire                   uc_valid_p2,
  input  wire                   take_p2,
  output wire                   grant_mc_p2,
  output wire                   grant_uc_p2,
  // Priority group 3 queues.
  input  wire                   mc_valid_p3,
  input  wire                   uc_valid_p3,
  input  wire                   take_p3,
  output wire                   grant_mc_p3,
  output wire                   grant_uc_p3
);

  wire        hit_p2;
  wire        hit_p3;
  wire        hit_status;
  wire        hit_any;
  wire        access_done;
  wire        wr_p2;
  wire        wr_p3;
  wire        en_p2;
  wire        sel_p2;
  wire [3:0]  wt_p2;
  wire        en_p3;
  wire        sel_p3;
  wire [3:0]  wt_p3;
  wire [31:0] rdata_p2;
  wire [31:0] rdata_p3;
  wire [3:0]  cnt_p2;
  wire [3:0]  cnt_p3;
  wire        last_uc_p2;
  wire        last_uc_p3;
  reg  [31:0] status_word;
  reg  [31:0] next_prdata;

  assign hit_p2     = (paddr == `EPW_OFS_PRIO2);
  assign hit_p3     = (paddr == `EPW_OFS_PRIO3);
  assign hit_status = (paddr == `EPW_OFS_STATUS);
  assign hit_any    = hit_p2 || hit_p3 || hit_status;

  // Read data is captured in the setup cycle so it comes from a flop while
  // the access phase still completes without wait states.
  assign pready      = psel && penable;
  assign pslverr     = psel && penable && !hit_any;
  assign access_done = psel && penable && pready;
  assign wr_p2       = access_done && pwrite && hit_p2;
  assign wr_p3       = access_done && pwrite && hit_p3;

  always @*
  begin
    status_word = 32'h00000000;
    status_word[`EPW_ST_CNT2_LO+3:`EPW_ST_CNT2_LO] = cnt_p2;
    status_word[`EPW_ST_LAST2]                     = last_uc_p2;
    status_word[`EPW_ST_CNT3_LO+3:`EPW_ST_CNT3_LO] = cnt_p3;
    status_word[`EPW_ST_LAST3]                     = last_uc_p3;
  end

  always @*
  begin
    next_prdata = 32'h00000000;
    if (hit_p2)
      next_prdata = rdata_p2;
    else if (hit_p3)
      next_prdata = rdata_p3;
    else if (hit_status)
      next_prdata = status_word;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  epw_pref_reg u_reg_p2
  (
    .pclk                  (pclk),
    .presetn               (presetn),
    .wr_en                 (wr_p2),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .weighted_pref_enable  (en_p2),
    .preferred_type_select (sel_p2),
    .weight                (wt_p2),
    .rdata                 (rdata_p2)
  );

  epw_pref_reg u_reg_p3
  (
    .pclk                  (pclk),
    .presetn               (presetn),
    .wr_en                 (wr_p3),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .weighted_pref_enable  (en_p3),
    .preferred_type_select (sel_p3),
    .weight                (wt_p3),
    .rdata                 (rdata_p3)
  );

  // Each group is steered only by its own register.
  epw_grp_arb u_arb_p2
  (
    .pclk                  (pclk),
    .presetn               (presetn),
    .weighted_pref_enable  (en_p2),
    .preferred_type_select (sel_p2),
    .weight                (wt_p2),
    .mc_valid              (mc_valid_p2),
    .uc_valid              (uc_valid_p2),
    .take                  (take_p2),
    .grant_mc              (grant_mc_p2),
    .grant_uc              (grant_uc_p2),
    .pref_count            (cnt_p2),
    .last_uc               (last_uc_p2)
  );

  epw_grp_arb u_arb_p3
  (
    .pclk                  (pclk),
    .presetn               (presetn),
    .weighted_pref_enable  (en_p3),
    .preferred_type_select (sel_p3),
    .weight                (wt_p3),
    .mc_valid              (mc_valid_p3),
    .uc_valid              (uc_valid_p3),
    .take                  (take_p3),
    .grant_mc              (grant_mc_p3),
    .grant_uc              (grant_uc_p3),
    .pref_count            (cnt_p3),
    .last_uc               (last_uc_p3)
  );

endmodule
`default_nettype wire

// ===== src/epw_grp_arb.v
// Multicast/unicast pick for one priority group of one egress port.
// Assumes the egress scheduler raises take in the cycle it consumes the
// packet that grant_mc or grant_uc names.
`timescale 1ns/100ps
`default_nettype none
`include "epw_map.vh"

module epw_grp_arb
(
  // Clock and reset.
  input  wire       pclk,
  input  wire       presetn,
  // Configuration.
  input  wire       weighted_pref_enable,
  input  wire       preferred_type_select,
  input  wire [3:0] weight,
  // Queues.
  input  wire       mc_valid,
  input  wire       uc_valid,
  input  wire       take,
  output reg        grant_mc,
  output reg        grant_uc,
  // State.
  output reg  [3:0] pref_count,
  output reg        last_uc
);

  wire pref_valid;
  wire other_valid;
  reg  pick_pref;
  reg  pick_other;

  assign pref_valid  = (preferred_type_select == `EPW_SEL_UCAST) ? uc_valid : mc_valid;
  assign other_valid = (preferred_type_select == `EPW_SEL_UCAST) ? mc_valid : uc_valid;

  always @*
  begin
    pick_pref  = 1'b0;
    pick_other = 1'b0;
    grant_mc   = 1'b0;
    grant_uc   = 1'b0;
    if (!weighted_pref_enable)
    begin
      // Plain alternation favours neither type.
      if (mc_valid && uc_valid)
      begin
        grant_mc = last_uc;
        grant_uc = !last_uc;
      end
      else
      begin
        grant_mc = mc_valid;
        grant_uc = uc_valid;
      end
    end
    else
    begin
      // Preferred type goes while its quota lasts or the other is absent.
      if (pref_valid && (!other_valid || (pref_count < weight)))
        pick_pref = 1'b1;
      else if (other_valid)
        pick_other = 1'b1;
      grant_uc = (preferred_type_select == `EPW_SEL_UCAST) ? pick_pref : pick_other;
      grant_mc = (preferred_type_select == `EPW_SEL_UCAST) ? pick_other : pick_pref;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pref_count <= 4'h0;
      last_uc    <= 1'b0;
    end
    else
    begin
      if (!weighted_pref_enable)
        pref_count <= 4'h0;
      else if (take && pick_other)
        pref_count <= 4'h0;
      else if (take && pick_pref && (pref_count != `EPW_WEIGHT_MAX))
        pref_count <= pref_count + 4'h1;
      if (take && (grant_mc || grant_uc))
        last_uc <= grant_uc;
    end
  end

endmodule
`default_nettype wire

// ===== src/epw_pref_reg.v
// One preference register: enable, preferred-type select and weight.
// Assumes the caller qualifies wr_en with a completed APB write.
`timescale 1ns/100ps
`default_nettype none
`include "epw_map.vh"

module epw_pref_reg
(
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // Write side.
  input  wire        wr_en,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  // Fields.
  output reg         weighted_pref_enable,
  output reg         preferred_type_select,
  output reg  [3:0]  weight,
  output wire [31:0] rdata
);

  // The reset word is all zeros, so every field clears to a plain constant.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      weighted_pref_enable  <= 1'b0;
      preferred_type_select <= 1'b0;
      weight                <= 4'h0;
    end
    else if (wr_en)
    begin
      if (pstrb[3])
      begin
        weighted_pref_enable  <= pwdata[`EPW_BIT_ENABLE];
        preferred_type_select <= pwdata[`EPW_BIT_SELECT];
      end
      if (pstrb[0])
        weight <= pwdata[`EPW_WEIGHT_HI:`EPW_WEIGHT_LO];
    end
  end

  // Reserved bits read as zero.
  assign rdata = {6'h00, weighted_pref_enable, preferred_type_select,
                  20'h00000, weight};

endmodule
`default_nettype wire
